/* shared/aaf_pkg.sv */
// Purpose: Shared constants and carriers for the acquisition FIFO/interrupt block
// Assumes: 40 MHz APB clock, 12-bit converter codes, 5-bit channel numbers
// Notes: Register offsets are byte addresses on a 32-bit APB bus
package aaf_pkg;
  // Clock rate and derived divider to the 2 MHz pacer time base
  localparam int unsigned CLK_KHZ = 40000;
  localparam int unsigned PACER_BASE_KHZ = 2000;
  localparam int unsigned PACER_DIV = CLK_KHZ / PACER_BASE_KHZ;
  // Longest conversion time, in ns; cycle count rounds down so the result is never late
  localparam int unsigned CONV_MAX_NS = 8500;
  localparam int unsigned CONV_CYC = (CONV_MAX_NS * (CLK_KHZ / 1000)) / 1000;
  // Data widths
  localparam int unsigned CODE_W = 12;
  localparam int unsigned CHAN_W = 5;
  localparam int unsigned TIMER_W = 16;
  // FIFO geometry
  localparam int unsigned FIFO_AW = 10;
  localparam int unsigned FIFO_DEPTH = 1024;
  localparam logic [FIFO_AW:0] FIFO_FULL_LVL = 11'h400;
  localparam logic [FIFO_AW:0] FIFO_HALF_LVL = 11'h200;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CHAN = 8'h04;
  localparam logic [7:0] OFS_SWTRIG = 8'h08;
  localparam logic [7:0] OFS_IRQCLR = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_PACER1 = 8'h14;
  localparam logic [7:0] OFS_PACER2 = 8'h18;
  localparam logic [7:0] OFS_DATA = 8'h1c;
  // Status field positions
  localparam int unsigned ST_NOT_EMPTY = 0;
  localparam int unsigned ST_IDLE = 1;
  localparam int unsigned ST_HALF = 2;
  localparam int unsigned ST_FULL = 3;
  localparam int unsigned ST_OVERRUN = 4;
  localparam int unsigned ST_ACQ_PEND = 5;
  localparam int unsigned ST_PACER_PEND = 6;
  // Data word field position of the channel number
  localparam int unsigned DATA_CHAN_POS = 16;
  // Reset values
  localparam logic [4:0] CTRL_RST = 5'h00;
  localparam logic [TIMER_W-1:0] PACER_RST = 16'h0000;

  // Control register; bit 0 is the lowest field listed last
  typedef struct packed {
    logic irq_gate;              // Bus-interface gate on the interrupt line
    logic fifo_disable;          // 1 holds the FIFO empty
    logic pacer_irq_en;          // Second request source on
    logic acq_irq_select;        // 0 end of conversion, 1 half full
    logic trigger_source_select; // 0 software, 1 pacer
  } aaf_ctrl_s;

  // One buffered sample
  typedef struct packed {
    logic [CHAN_W-1:0] chan;
    logic [CODE_W-1:0] code;
  } aaf_sample_s;
endpackage : aaf_pkg

/* hdl/aaf_pacer_cnt.sv */
// Purpose: One reloading down counter stage of the pacer chain
// Assumes: tick is a one-cycle enable on pclk
// Notes: Reload of 0 or 1 pulses on every tick
`timescale 1ns/1ps
`default_nettype none
module aaf_pacer_cnt (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick,
  input wire logic [aaf_pkg::TIMER_W-1:0] reload,
  output logic pulse
);
  // Counter state
  typedef struct packed {
    logic [aaf_pkg::TIMER_W-1:0] cnt;
    logic pulse;
  } aaf_pcnt_s;

  aaf_pcnt_s st_r;
  aaf_pcnt_s st_nxt;

  // Count down on each tick, reload and pulse at the bottom
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.pulse = 1'b0;
    if (tick)
    begin
      if (st_r.cnt <= 16'h0001)
      begin
        st_nxt.cnt = reload;
        st_nxt.pulse = 1'b1;
      end
      else
      begin
        st_nxt.cnt = st_r.cnt - 16'h0001;
      end
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign pulse = st_r.pulse;
endmodule : aaf_pacer_cnt
`default_nettype wire

/* hdl/aaf_fifo.sv */
// Purpose: 1024-word sample FIFO in flip-flops
// Assumes: Writes while full and reads while empty are dropped
// Notes: Read data is the head word, shown without a read strobe
`timescale 1ns/1ps
`default_nettype none
module aaf_fifo (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clear,
  input wire logic wr_en,
  input wire aaf_pkg::aaf_sample_s wr_data,
  input wire logic rd_en,
  output aaf_pkg::aaf_sample_s rd_data,
  output logic [aaf_pkg::FIFO_AW:0] count
);
  // Storage and pointers
  typedef struct packed {
    aaf_pkg::aaf_sample_s [aaf_pkg::FIFO_DEPTH-1:0] mem;
    logic [aaf_pkg::FIFO_AW-1:0] wptr;
    logic [aaf_pkg::FIFO_AW-1:0] rptr;
    logic [aaf_pkg::FIFO_AW:0] cnt;
  } aaf_fifo_s;

  aaf_fifo_s st_r;
  aaf_fifo_s st_nxt;
  logic do_wr;
  logic do_rd;

  // Guard against over- and underflow here so callers need not
  assign do_wr = wr_en && (st_r.cnt != aaf_pkg::FIFO_FULL_LVL);
  assign do_rd = rd_en && (st_r.cnt != '0);

  // Pointer and occupancy update; clear wins over everything
  always_comb
  begin
    st_nxt = st_r;
    if (clear)
    begin
      st_nxt.wptr = '0;
      st_nxt.rptr = '0;
      st_nxt.cnt = '0;
    end
    else
    begin
      if (do_wr)
      begin
        st_nxt.mem[st_r.wptr] = wr_data;
        st_nxt.wptr = st_r.wptr + 10'h001;
      end
      if (do_rd)
        st_nxt.rptr = st_r.rptr + 10'h001;
      if (do_wr && !do_rd)
        st_nxt.cnt = st_r.cnt + 11'h001;
      else if (do_rd && !do_wr)
        st_nxt.cnt = st_r.cnt - 11'h001;
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign rd_data = st_r.mem[st_r.rptr];
  assign count = st_r.cnt;
endmodule : aaf_fifo
`default_nettype wire

/* hdl/aaf_acq_top.sv */
// Purpose: Converter acquisition control with FIFO, status and dual interrupt request
// Assumes: Converter code arrives on pins and is sampled at end of conversion
// Notes: APB slave answers every access with one access cycle, no extra waits
//
// Summary of operation
// - Pacer mode starts conversions from cascaded counters
// - Trigger, transfer and interrupt set independently
// - Results go into 1024-word FIFO unless full or disabled
// - Full FIFO drops results, flags overrun
// - Not-empty flag rises once result stored
// - Idle flag low while converting, high after
// - Result in FIFO within 8.5 us
// - Half-full flag at 512 words
// - End-of-conversion mode requests on each stored result
// - Half-full mode requests on reaching 512
// - Results are unsigned 12-bit codes
// - Two requests may be pending together
// - Both requests drive one interrupt line
// - First request selectable, second pacer only
// - Two select bits plus bus gate
// - Software mode: any trigger write converts once if idle; writes during a conversion are ignored
// - Select 0 end of conversion, 1 half full
// - FIFO disable 0 enables; 0-1-0 empties
// - Any clear write drops pending requests, except one whose new event lands in the same cycle
`timescale 1ns/1ps
`default_nettype none
module aaf_acq_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [aaf_pkg::CODE_W-1:0] adc_code_pin,
  output logic inta_n_o,
  output logic inta_n_oe
);
  // Cycles from the cycle that raises start to the cycle that shows eoc
  localparam int CONV_DLY = aaf_pkg::CONV_CYC - 1;

  // Whole block state
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    aaf_pkg::aaf_ctrl_s ctrl;
    logic [aaf_pkg::CHAN_W-1:0] chan;
    logic [aaf_pkg::TIMER_W-1:0] div1;
    logic [aaf_pkg::TIMER_W-1:0] div2;
    logic [4:0] presc;
    logic tick;
    logic busy;
    logic [8:0] conv_cnt;
    logic [aaf_pkg::CODE_W-1:0] adc_s1;
    logic [aaf_pkg::CODE_W-1:0] adc_s2;
    logic ovr;
    logic acq_pend;
    logic pacer_pend;
    logic half_q;
    logic inta_oe;
  } aaf_top_s;

  aaf_top_s st_r;
  aaf_top_s st_nxt;

  logic stage1_pulse;       // First pacer stage output
  logic pacer_pulse;        // Cascaded pacer output
  aaf_pkg::aaf_sample_s fifo_head;
  aaf_pkg::aaf_sample_s fifo_in;
  logic [aaf_pkg::FIFO_AW:0] fcount;
  logic fempty;
  logic ffull;
  logic half;
  logic setup_ph;           // APB setup cycle
  logic access_ph;          // APB completing access
  logic wr_acc;
  logic soft_trig;
  logic start;
  logic eoc;
  logic fifo_wr;
  logic fifo_pop;
  logic irq_clr;
  logic acq_set;
  logic pacer_set;

  // Two cascaded counters give the fixed sampling period
  aaf_pacer_cnt u_pacer1 (
    .pclk(pclk),
    .presetn(presetn),
    .tick(st_r.tick),
    .reload(st_r.div1),
    .pulse(stage1_pulse)
  );

  aaf_pacer_cnt u_pacer2 (
    .pclk(pclk),
    .presetn(presetn),
    .tick(stage1_pulse),
    .reload(st_r.div2),
    .pulse(pacer_pulse)
  );

  // Sample buffer; disable holds it empty so 0-1-0 flushes it
  aaf_fifo u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .clear(st_r.ctrl.fifo_disable),
    .wr_en(fifo_wr),
    .wr_data(fifo_in),
    .rd_en(fifo_pop),
    .rd_data(fifo_head),
    .count(fcount)
  );

  // Bus phase decode
  assign setup_ph = psel && !penable;
  assign access_ph = psel && penable && st_r.pready;
  assign wr_acc = access_ph && pwrite;

  // Flags from occupancy
  assign fempty = (fcount == '0);
  assign ffull = (fcount == aaf_pkg::FIFO_FULL_LVL);
  assign half = (fcount >= aaf_pkg::FIFO_HALF_LVL);

  // Software trigger counts only in software mode, any data value
  assign soft_trig = wr_acc && (paddr == aaf_pkg::OFS_SWTRIG) && !st_r.ctrl.trigger_source_select;
  // Triggers during a conversion are ignored; the converter cannot restart
  assign start = !st_r.busy && (soft_trig || (st_r.ctrl.trigger_source_select && pacer_pulse));
  // Conversion ends when the cycle budget runs out
  assign eoc = st_r.busy && (st_r.conv_cnt == '0);
  // Store unless full or disabled; a full FIFO drops the word
  assign fifo_wr = eoc && !st_r.ctrl.fifo_disable && !ffull;
  // Unsigned code kept as converted, with the channel beside it
  assign fifo_in = '{chan: st_r.chan, code: st_r.adc_s2};
  // Data read removes one word; empty reads leave occupancy alone
  assign fifo_pop = access_ph && !pwrite && (paddr == aaf_pkg::OFS_DATA) && !fempty;
  assign irq_clr = wr_acc && (paddr == aaf_pkg::OFS_IRQCLR);
  // First request source: stored result or half-full edge
  assign acq_set = st_r.ctrl.acq_irq_select ? (half && !st_r.half_q) : fifo_wr;
  // Second request comes from the pacer only
  assign pacer_set = st_r.ctrl.pacer_irq_en && pacer_pulse;

  // Next-state logic for bus, converter and request flags
  always_comb
  begin
    st_nxt = st_r;
    // Pin input synchroniser; stage one feeds only stage two
    st_nxt.adc_s1 = adc_code_pin;
    st_nxt.adc_s2 = st_r.adc_s1;
    // Divider to the pacer time base
    st_nxt.tick = 1'b0;
    if (st_r.presc == 5'(aaf_pkg::PACER_DIV - 1))
    begin
      st_nxt.presc = '0;
      st_nxt.tick = 1'b1;
    end
    else
    begin
      st_nxt.presc = st_r.presc + 5'h01;
    end
    // Bus answer is prepared in setup and shown in the access cycle
    st_nxt.pready = setup_ph;
    if (setup_ph)
    begin
      st_nxt.pslverr = 1'b0;
      st_nxt.prdata = '0;
      case (paddr)
        aaf_pkg::OFS_CTRL: st_nxt.prdata = {27'h0000000, st_r.ctrl};
        aaf_pkg::OFS_CHAN: st_nxt.prdata = {27'h0000000, st_r.chan};
        aaf_pkg::OFS_PACER1: st_nxt.prdata = {16'h0000, st_r.div1};
        aaf_pkg::OFS_PACER2: st_nxt.prdata = {16'h0000, st_r.div2};
        aaf_pkg::OFS_SWTRIG, aaf_pkg::OFS_IRQCLR: st_nxt.prdata = '0; // Write-only, read zero
        aaf_pkg::OFS_STATUS:
        begin
          st_nxt.prdata[aaf_pkg::ST_NOT_EMPTY] = !fempty;
          st_nxt.prdata[aaf_pkg::ST_IDLE] = !st_r.busy;
          st_nxt.prdata[aaf_pkg::ST_HALF] = half;
          st_nxt.prdata[aaf_pkg::ST_FULL] = ffull;
          st_nxt.prdata[aaf_pkg::ST_OVERRUN] = st_r.ovr;
          st_nxt.prdata[aaf_pkg::ST_ACQ_PEND] = st_r.acq_pend;
          st_nxt.prdata[aaf_pkg::ST_PACER_PEND] = st_r.pacer_pend;
        end
        aaf_pkg::OFS_DATA:
        begin
          // Head word, zero when nothing is buffered
          if (!fempty)
          begin
            st_nxt.prdata[aaf_pkg::CODE_W-1:0] = fifo_head.code;
            st_nxt.prdata[aaf_pkg::DATA_CHAN_POS +: aaf_pkg::CHAN_W] = fifo_head.chan;
          end
        end
        default: st_nxt.pslverr = 1'b1; // Unmapped address
      endcase
    end
    // Register writes take effect at the completing edge
    if (wr_acc)
    begin
      case (paddr)
        aaf_pkg::OFS_CTRL: st_nxt.ctrl = pwdata[4:0];
        aaf_pkg::OFS_CHAN: st_nxt.chan = pwdata[aaf_pkg::CHAN_W-1:0];
        aaf_pkg::OFS_PACER1: st_nxt.div1 = pwdata[aaf_pkg::TIMER_W-1:0];
        aaf_pkg::OFS_PACER2: st_nxt.div2 = pwdata[aaf_pkg::TIMER_W-1:0];
        default: st_nxt.chan = st_r.chan; // Read-only or strobe-only
      endcase
    end
    // Conversion sequencer
    if (start)
    begin
      st_nxt.busy = 1'b1;
      // Trigger edge is cycle one and the store lands one edge after eoc, so the word is in at edge 340
      st_nxt.conv_cnt = 9'(aaf_pkg::CONV_CYC - 2);
    end
    else if (eoc)
    begin
      st_nxt.busy = 1'b0;
    end
    else if (st_r.busy)
    begin
      st_nxt.conv_cnt = st_r.conv_cnt - 9'h001;
    end
    // Overrun is sticky until the FIFO is flushed; a drop while disabled is not flagged
    st_nxt.ovr = (st_r.ovr && !st_r.ctrl.fifo_disable) || (eoc && ffull && !st_r.ctrl.fifo_disable);
    st_nxt.half_q = half;
    // Pending requests; a new event beats a clear in the same cycle
    st_nxt.acq_pend = (st_r.acq_pend && !irq_clr) || acq_set;
    st_nxt.pacer_pend = (st_r.pacer_pend && !irq_clr) || pacer_set;
    // Both requests share one gated, level-sensitive line
    st_nxt.inta_oe = st_r.ctrl.irq_gate && (st_r.acq_pend || st_r.pacer_pend);
  end

  // State register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r <= '0;
      st_r.ctrl <= aaf_pkg::CTRL_RST;
      st_r.div1 <= aaf_pkg::PACER_RST;
      st_r.div2 <= aaf_pkg::PACER_RST;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from state; the line only ever drives low
  assign prdata = st_r.prdata;
  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign inta_n_o = 1'b0;
  assign inta_n_oe = st_r.inta_oe;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Conversion finishes exactly at the budget
  conv_time_a: assert property (start |-> ##[CONV_DLY:CONV_DLY] eoc)
    else $error("conversion did not end on time");
  // Pacer pulse starts an idle converter in pacer mode
  pacer_trig_a: assert property ((st_r.ctrl.trigger_source_select && pacer_pulse && !st_r.busy) |=> st_r.busy)
    else $error("pacer pulse did not start conversion");
  // Software trigger starts an idle converter in software mode
  soft_trig_a: assert property (soft_trig && !st_r.busy |=> st_r.busy && !pready)
    else $error("software trigger ignored");
  // Stored result raises the not-empty flag
  store_flag_a: assert property (fifo_wr && !fifo_pop |=> !fempty && fcount == $past(fcount) + 11'h001)
    else $error("result not stored");
  // A result meeting a full FIFO is lost and flagged
  overrun_drop_a: assert property ((eoc && ffull && !st_r.ctrl.fifo_disable && !fifo_pop) |=> st_r.ovr && ffull)
    else $error("overrun not flagged");
  // End-of-conversion mode requests on each stored result
  eoc_irq_a: assert property ((!st_r.ctrl.acq_irq_select && fifo_wr) |=> st_r.acq_pend)
    else $error("eoc request missing");
  // Half-full mode requests when occupancy reaches the half level
  half_irq_a: assert property ((st_r.ctrl.acq_irq_select && $rose(half)) |=> st_r.acq_pend)
    else $error("half-full request missing");
  // Clear write drops requests when no new event arrives
  irq_clear_a: assert property ((irq_clr && !acq_set && !pacer_set) |=> !st_r.acq_pend && !st_r.pacer_pend)
    else $error("clear did not drop requests");
  // Either pending request drives the shared line within a cycle
  inta_line_a: assert property ((st_r.ctrl.irq_gate && (st_r.acq_pend || st_r.pacer_pend)) |=> inta_n_oe)
    else $error("interrupt line not driven");
  // Data read pops exactly one word
  pop_one_a: assert property ((fifo_pop && !fifo_wr && !st_r.ctrl.fifo_disable) |=> fcount == $past(fcount) - 11'h001)
    else $error("read did not pop one word");
endmodule : aaf_acq_top
`default_nettype wire

/* tb/aaf_adc_model.sv */
// Purpose: Converter front end and pulled-up interrupt wire for the bench
// Assumes: The analog level stays put across each conversion
// Notes: The shared interrupt line floats high through a pull-up when released
`timescale 1ns/1ps
`default_nettype none
module aaf_adc_model (
  input wire logic [aaf_pkg::CODE_W-1:0] level,
  input wire logic inta_n_o,
  input wire logic inta_n_oe,
  output logic [aaf_pkg::CODE_W-1:0] adc_code_pin,
  output logic inta_wire
);
  // Pins follow the level the bench sets; codes cover 0 to 4095 unchanged
  assign adc_code_pin = level;
  // Open-drain line: low only while driven, else the pull-up wins
  assign inta_wire = inta_n_oe ? inta_n_o : 1'b1;
endmodule : aaf_adc_model
`default_nettype wire

/* tb/tb.sv */
// Purpose: Self-checking bench for acquisition control, FIFO and interrupt
// Assumes: APB answers in one access cycle; conversion takes 340 cycles
// Notes: Filling to 512 words is too long for this run, so half-full mode is selected but never reached
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic inta_n_o, inta_n_oe, inta_wire, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [11:0] level, adc_code_pin;
  // Boundary codes: bottom, bipolar zero, top
  logic [11:0] codes [3] = '{12'h000, 12'h800, 12'hfff};
  int failures = 0;
  int num_checks = 0;

  aaf_acq_top aaf_acq_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .adc_code_pin(adc_code_pin), .inta_n_o(inta_n_o), .inta_n_oe(inta_n_oe));
  aaf_adc_model aaf_adc_model_i (.level(level), .inta_n_o(inta_n_o), .inta_n_oe(inta_n_oe),
    .adc_code_pin(adc_code_pin), .inta_wire(inta_wire));

  // Free-running 40 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // The slave sets the pace; only the watchdog ends a hung wait
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    // Answer taken at the completing edge, then the request is released
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Read and compare a register
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rchk

  // Look at the interrupt wire away from the clock edge
  task automatic wire_chk(input logic exp);
    @(negedge pclk);
    chk({31'h0, inta_wire}, {31'h0, exp});
  endtask : wire_chk

  task automatic t_reset;
    rchk(aaf_pkg::OFS_CTRL, 32'h0);
    rchk(aaf_pkg::OFS_STATUS, 32'h2);
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, err}, 32'h1);
    rchk(aaf_pkg::OFS_DATA, 32'h0);
    rchk(aaf_pkg::OFS_STATUS, 32'h2);
    $display("reset test done");
  endtask : t_reset

  // Software conversions over boundary codes and channels
  task automatic t_swconv;
    for (int i = 0; i < 3; i++)
    begin
      level <= codes[i];
      apb(1'b1, aaf_pkg::OFS_CHAN, 32'(i + 29));
      apb(1'b1, aaf_pkg::OFS_SWTRIG, 32'h5a);
      rchk(aaf_pkg::OFS_STATUS, 32'h0);
      // Timed so the read sees the state just after the 341st edge
      repeat (336) @(posedge pclk);
      // End-of-conversion mode is the reset default, so each result also leaves a request pending
      rchk(aaf_pkg::OFS_STATUS, 32'h23);
      rchk(aaf_pkg::OFS_DATA, {11'h0, 5'(i + 29), 4'h0, codes[i]});
      rchk(aaf_pkg::OFS_STATUS, 32'h22);
      apb(1'b1, aaf_pkg::OFS_IRQCLR, 32'h0);
    end
    $display("software conversion test done");
  endtask : t_swconv

  // Source select, gate and clear of the first request
  task automatic t_irq;
    apb(1'b1, aaf_pkg::OFS_CTRL, 32'h12);
    apb(1'b1, aaf_pkg::OFS_SWTRIG, 32'h0);
    repeat (345) @(posedge pclk);
    rchk(aaf_pkg::OFS_STATUS, 32'h3);
    apb(1'b1, aaf_pkg::OFS_CTRL, 32'h10);
    apb(1'b1, aaf_pkg::OFS_SWTRIG, 32'h1);
    repeat (345) @(posedge pclk);
    rchk(aaf_pkg::OFS_STATUS, 32'h23);
    wire_chk(1'b0);
    apb(1'b1, aaf_pkg::OFS_IRQCLR, 32'h77);
    repeat (2) @(posedge pclk);
    wire_chk(1'b1);
    rchk(aaf_pkg::OFS_STATUS, 32'h3);
    // Drain both buffered words back to back, no status check between them
    rchk(aaf_pkg::OFS_DATA, 32'h001f0fff);
    rchk(aaf_pkg::OFS_DATA, 32'h001f0fff);
    $display("interrupt test done");
  endtask : t_irq

  // Pacer triggering with both requests pending, gate off, then flush
  task automatic t_pacer;
    apb(1'b1, aaf_pkg::OFS_PACER1, 32'h1);
    apb(1'b1, aaf_pkg::OFS_PACER2, 32'h1);
    apb(1'b1, aaf_pkg::OFS_CTRL, 32'h05);
    repeat (400) @(posedge pclk);
    apb(1'b0, aaf_pkg::OFS_STATUS, 32'h0);
    chk(rd & 32'h61, 32'h61);
    wire_chk(1'b1);
    apb(1'b1, aaf_pkg::OFS_CTRL, 32'h00);
    // Let any conversion in flight finish before clearing
    repeat (360) @(posedge pclk);
    apb(1'b1, aaf_pkg::OFS_IRQCLR, 32'h0);
    rchk(aaf_pkg::OFS_STATUS, 32'h3);
    apb(1'b1, aaf_pkg::OFS_CTRL, 32'h08);
    apb(1'b1, aaf_pkg::OFS_CTRL, 32'h00);
    rchk(aaf_pkg::OFS_STATUS, 32'h2);
    rchk(aaf_pkg::OFS_DATA, 32'h0);
    $display("pacer test done");
  endtask : t_pacer

  // Counts, verdict and end of run
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : wrap_up

  // Main sequence: inputs settled at time zero, reset held 4 cycles
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    level = 12'h000;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_swconv();
    t_irq();
    t_pacer();
    wrap_up();
  end

  // Watchdog: run needs about 2600 cycles
  initial
  begin
    repeat (20000) @(posedge pclk);
    failures++;
    wrap_up();
  end
endmodule : tb
`default_nettype wire
